/* File: verilog/gpp_port.v */
`timescale 1ns/10ps
`include "gpp_defs.vh"
module gpp_port (
  // Clock and reset.
  input  wire                     clk,
  input  wire                     rst_n,
  // Register port.
  input  wire [`GPP_ADDR_W-1:0]   addr,
  input  wire [7:0]               wdata,
  input  wire                     wr,
  input  wire                     rd,
  output reg  [7:0]               rdata,
  // First port pins.
  input  wire [`GPP_PA_WIDTH-1:0] pa_i,
  output reg  [`GPP_PA_WIDTH-1:0] pa_o,
  output reg  [`GPP_PA_WIDTH-1:0] pa_oe_n,
  output reg  [`GPP_PA_WIDTH-1:0] pa_pull_en,
  // Second port pins.
  input  wire [`GPP_PB_WIDTH-1:0] pb_i,
  output reg  [`GPP_PB_WIDTH-1:0] pb_o,
  output reg  [`GPP_PB_WIDTH-1:0] pb_oe_n,
  output reg  [`GPP_PB_WIDTH-1:0] pb_pull_en,
  // Keyboard interrupt and external interrupt views.
  output reg  [`GPP_PA_WIDTH-1:0] keyboard_interrupt_in,
  output reg  [`GPP_PA_WIDTH-1:0] keyboard_interrupt_en,
  output reg                      ext_int_enable,
  output reg                      ext_int_level,
  output reg                      branch_if_int_high,
  output reg                      branch_if_int_low
);

  // Pins that have an output driver on the first port.
  localparam [`GPP_PA_WIDTH-1:0] PA_DRIVE_MASK = 6'h3b;

  // Software registers.
  reg [`GPP_PA_WIDTH-1:0] first_port_data;        // First port output latch.
  reg [`GPP_PA_WIDTH-1:0] first_port_direction;   // First port direction, 1 = output.
  reg [`GPP_PA_WIDTH-1:0] first_port_pullup;      // First port pull-up enables.
  reg [`GPP_PB_WIDTH-1:0] second_port_data;       // Second port output latch.
  reg [`GPP_PB_WIDTH-1:0] second_port_direction;  // Second port direction, 1 = output.
  reg [`GPP_PB_WIDTH-1:0] port_b_pullup_enable;   // Second port pull-up enables.
  reg [7:0]               config_register_two;    // Bit 0 enables the external interrupt.
  reg [`GPP_PA_WIDTH-1:0] kb_enable;              // Keyboard interrupt pin enables.

  // Synchronised pin levels and read mux.
  wire [`GPP_PA_WIDTH-1:0] pa_sync;
  wire [`GPP_PB_WIDTH-1:0] pb_sync;
  wire [`GPP_PA_WIDTH-1:0] pa_ctl_o;
  wire [`GPP_PA_WIDTH-1:0] pa_ctl_oe_n;
  wire [`GPP_PA_WIDTH-1:0] pa_ctl_pull;
  wire [`GPP_PB_WIDTH-1:0] pb_ctl_o;
  wire [`GPP_PB_WIDTH-1:0] pb_ctl_oe_n;
  wire [`GPP_PB_WIDTH-1:0] pb_ctl_pull;
  wire                     irq_on;
  reg  [7:0]               next_rdata;
  reg  [`GPP_PA_WIDTH-1:0] pa_view;
  wire [7:0]               pa_mix;   // Full-width read mix before the upper bits are cut.

  assign irq_on = config_register_two[`GPP_CFG2_IRQEN_BIT];

  // Data read view: pin level for inputs, latch for outputs.
  function [7:0] mix_read;
    input [7:0] pins;
    input [7:0] latch;
    input [7:0] dir;
    begin
      mix_read = (pins & ~dir) | (latch & dir);
    end
  endfunction

  // Pins are asynchronous to clk, so each passes two flops first.
  gpp_sync #(.W(`GPP_PA_WIDTH)) u_sync_a (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pa_i),
    .q     (pa_sync)
  );

  gpp_sync #(.W(`GPP_PB_WIDTH)) u_sync_b (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pb_i),
    .q     (pb_sync)
  );

  // First port drivers; the shared pin has no driver at all.
  gpp_pin_ctl #(.W(`GPP_PA_WIDTH)) u_ctl_a (
    .clk        (clk),
    .rst_n      (rst_n),
    .latch      (first_port_data),
    .dir        (first_port_direction),
    .pullup_en  (first_port_pullup),
    .drive_mask (PA_DRIVE_MASK),
    .pin_o      (pa_ctl_o),
    .pin_oe_n   (pa_ctl_oe_n),
    .pull_en    (pa_ctl_pull)
  );

  // Second port drivers with direction-qualified pull-ups.
  gpp_pin_ctl #(.W(`GPP_PB_WIDTH)) u_ctl_b (
    .clk        (clk),
    .rst_n      (rst_n),
    .latch      (second_port_data),
    .dir        (second_port_direction),
    .pullup_en  (port_b_pullup_enable),
    .drive_mask ({`GPP_PB_WIDTH{1'b1}}),
    .pin_o      (pb_ctl_o),
    .pin_oe_n   (pb_ctl_oe_n),
    .pull_en    (pb_ctl_pull)
  );

  // Pin controls are already registered in the submodule; these copy them to
  // the top outputs so every output stems from a flop in this module too.
  // The copy adds one cycle, which is harmless next to pin electrical delay.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_o       <= `GPP_RST_PA;
      pa_oe_n    <= 6'h3f;
      pa_pull_en <= `GPP_RST_PA;
      pb_o       <= `GPP_RST_PB;
      pb_oe_n    <= 8'hff;
      pb_pull_en <= `GPP_RST_PB;
    end else begin
      pa_o       <= pa_ctl_o;
      pa_oe_n    <= pa_ctl_oe_n;
      pa_pull_en <= pa_ctl_pull;
      pb_o       <= pb_ctl_o;
      pb_oe_n    <= pb_ctl_oe_n;
      pb_pull_en <= pb_ctl_pull;
    end
  end

  // Register writes; reads never change state here.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_port_data       <= `GPP_RST_PA;
      first_port_direction  <= `GPP_RST_PA;
      first_port_pullup     <= `GPP_RST_PA;
      second_port_data      <= `GPP_RST_PB;
      second_port_direction <= `GPP_RST_PB;
      port_b_pullup_enable  <= `GPP_RST_PB;
      config_register_two   <= `GPP_RST_CFG2;
      kb_enable             <= `GPP_RST_PA;
    end else if (wr) begin
      case (addr)
        `GPP_OFF_PA_DATA: begin
          first_port_data <= wdata[`GPP_PA_WIDTH-1:0];
        end
        `GPP_OFF_PA_DIR: begin
          first_port_direction <= wdata[`GPP_PA_WIDTH-1:0];
        end
        `GPP_OFF_PA_PULLUP: begin
          first_port_pullup <= wdata[`GPP_PA_WIDTH-1:0];
        end
        `GPP_OFF_PB_DATA: begin
          // Latch updates even on input pins; the input read is untouched.
          second_port_data <= wdata;
        end
        `GPP_OFF_PB_DIR: begin
          second_port_direction <= wdata;
        end
        `GPP_OFF_PB_PULLUP: begin
          port_b_pullup_enable <= wdata;
        end
        `GPP_OFF_CFG_TWO: begin
          config_register_two <= wdata;
        end
        `GPP_OFF_KB_ENABLE: begin
          kb_enable <= wdata[`GPP_PA_WIDTH-1:0];
        end
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
  end

  // The mix runs at byte width; only the six port bits are kept.
  assign pa_mix = mix_read({2'b00, pa_sync}, {2'b00, first_port_data},
                           {2'b00, first_port_direction & PA_DRIVE_MASK});

  // First port read view, with the shared bit handled per interrupt mode.
  always @* begin
    pa_view = pa_mix[`GPP_PA_WIDTH-1:0];
    // The shared pin is always an input, so the pin level is the base value.
    pa_view[`GPP_SHARED_BIT] = irq_on ? 1'b0 : pa_sync[`GPP_SHARED_BIT];
  end

  // Read decode; unmapped addresses return zero.
  always @* begin
    next_rdata = `GPP_RST_RDATA;
    case (addr)
      `GPP_OFF_PA_DATA:    next_rdata = {2'b00, pa_view};
      `GPP_OFF_PA_DIR:     next_rdata = {2'b00, first_port_direction};
      `GPP_OFF_PA_PULLUP:  next_rdata = {2'b00, first_port_pullup};
      `GPP_OFF_PB_DATA:    next_rdata = mix_read(pb_sync, second_port_data,
                                                 second_port_direction);
      `GPP_OFF_PB_DIR:     next_rdata = second_port_direction;
      `GPP_OFF_PB_PULLUP:  next_rdata = port_b_pullup_enable;
      `GPP_OFF_CFG_TWO:    next_rdata = config_register_two;
      `GPP_OFF_KB_ENABLE:  next_rdata = {2'b00, kb_enable};
      default:             next_rdata = `GPP_RST_RDATA;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `GPP_RST_RDATA;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= `GPP_RST_RDATA;
    end
  end

  // Interrupt-side views of the pins.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyboard_interrupt_in <= `GPP_RST_PA;
      keyboard_interrupt_en <= `GPP_RST_PA;
      ext_int_enable        <= 1'b0;
      ext_int_level         <= 1'b1;
      branch_if_int_high    <= 1'b1;
      branch_if_int_low     <= 1'b0;
    end else begin
      // Every first-port pin feeds the keyboard interrupt logic.
      keyboard_interrupt_in <= pa_sync;
      keyboard_interrupt_en <= kb_enable;
      ext_int_enable        <= irq_on;
      // Disabled mode reports a steady high to the branch test.
      ext_int_level      <= irq_on ? pa_sync[`GPP_SHARED_BIT] : 1'b1;
      branch_if_int_high <= irq_on ? pa_sync[`GPP_SHARED_BIT] : 1'b1;
      branch_if_int_low  <= irq_on ? ~pa_sync[`GPP_SHARED_BIT] : 1'b0;
    end
  end

endmodule

/* File: verilog/gpp_defs.vh */
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH

// Register offsets on the plain register port (byte addresses).
`define GPP_ADDR_W          4
`define GPP_OFF_PA_DATA     4'h0
`define GPP_OFF_PA_DIR      4'h1
`define GPP_OFF_PA_PULLUP   4'h2
`define GPP_OFF_PB_DATA     4'h3
`define GPP_OFF_PB_DIR      4'h4
`define GPP_OFF_PB_PULLUP   4'h5
`define GPP_OFF_CFG_TWO     4'h6
`define GPP_OFF_KB_ENABLE   4'h7

// Field positions.
`define GPP_PA_WIDTH        6
`define GPP_PB_WIDTH        8
`define GPP_SHARED_BIT      2
`define GPP_CFG2_IRQEN_BIT  0

// Reset values.
`define GPP_RST_PA          6'h00
`define GPP_RST_PB          8'h00
`define GPP_RST_CFG2        8'h00
`define GPP_RST_RDATA       8'h00

`endif

/* File: verilog/gpp_sync.v */
`timescale 1ns/10ps
// Two-flop synchroniser for a bundle of pin levels.
module gpp_sync #(
  parameter W = 8
) (
  // Clock and reset.
  input  wire         clk,
  input  wire         rst_n,
  // Asynchronous pin levels in, synchronised levels out.
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;  // First stage, read only by the second stage.

  // Both stages clear to zero so no X leaks into the read path.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: verilog/gpp_pin_ctl.v */
`timescale 1ns/10ps
`include "gpp_defs.vh"
// Per-pin driver and pull-up control for one port, registered outputs.
module gpp_pin_ctl #(
  parameter W = 8
) (
  // Clock and reset.
  input  wire         clk,
  input  wire         rst_n,
  // Software state.
  input  wire [W-1:0] latch,
  input  wire [W-1:0] dir,
  input  wire [W-1:0] pullup_en,
  input  wire [W-1:0] drive_mask,
  // Pin control, output enable active low.
  output reg  [W-1:0] pin_o,
  output reg  [W-1:0] pin_oe_n,
  output reg  [W-1:0] pull_en
);

  // Drivers follow direction; pull-ups only act on inputs.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o    <= {W{1'b0}};
      pin_oe_n <= {W{1'b1}};
      pull_en  <= {W{1'b0}};
    end else begin
      pin_o    <= latch & drive_mask;
      // Masked pins never drive, whatever their direction bit.
      pin_oe_n <= ~(dir & drive_mask);
      // An output pin drops its pull-up at once; a clear enable floats the input.
      pull_en  <= pullup_en & ~(dir & drive_mask);
    end
  end

endmodule

/* File: verification/gpp_pins.sv */
`timescale 1ns/10ps
// Outside world at the pins: the block wins, then an outside driver, then the pull-up.
module gpp_pins #(
  parameter W = 8
) (
  // Clock.
  input  wire         clk,
  // Block side.
  input  wire [W-1:0] o,
  input  wire [W-1:0] oe_n,
  input  wire [W-1:0] pull_en,
  // Outside drivers.
  input  wire [W-1:0] ext_v,
  input  wire [W-1:0] ext_en,
  // Resolved pin levels.
  output reg  [W-1:0] pin
);
  reg [W-1:0] float_q = {W{1'b0}}; // A floating pin wanders, so nobody may rely on it.
  integer     i;
  // Toggle the floating level each cycle.
  always @(posedge clk) float_q <= ~float_q;
  // Resolve each pin separately.
  always @* begin
    for (i = 0; i < W; i = i + 1) begin
      if (!oe_n[i]) pin[i] = o[i];
      else if (ext_en[i]) pin[i] = ext_v[i];
      else if (pull_en[i]) pin[i] = 1'b1;
      else pin[i] = float_q[i];
    end
  end
endmodule

/* File: verification/gpp_port_props.sv */
`timescale 1ns/10ps
`include "gpp_defs.vh"
// Port checker; every relation is sampled on clk.
module gpp_port_props (
  // Clock, reset and register port.
  input wire       clk,
  input wire       rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  // Pins and views.
  input wire [5:0] pa_i,
  input wire [5:0] pa_o,
  input wire [5:0] pa_oe_n,
  input wire [5:0] pa_pull_en,
  input wire [7:0] pb_oe_n,
  input wire [7:0] pb_pull_en,
  input wire       ext_int_enable,
  input wire       branch_if_int_high,
  input wire       branch_if_int_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (rd && addr > `GPP_OFF_KB_ENABLE |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bit2_masked: assert property (rd && addr == `GPP_OFF_PA_DATA ##1 ext_int_enable
    |-> rdata[2] == 1'b0) else $error("shared bit read not zero");
  a_pa_upper: assert property (rd && addr == `GPP_OFF_PA_DATA |=> rdata[7:6] == 2'b00)
    else $error("first port upper bits set");
  a_shared_input: assert property (pa_oe_n[2] && !pa_o[2])
    else $error("shared pin driven");
  a_pa_pull_in: assert property ((pa_pull_en & ~pa_oe_n) == 6'h00)
    else $error("first port pull on output");
  a_pb_pull_out: assert property ((pb_pull_en & ~pb_oe_n) == 8'h00)
    else $error("second port pull on output");
  a_branch_off: assert property (!ext_int_enable && !$past(ext_int_enable)
    |-> branch_if_int_high && !branch_if_int_low) else $error("branch not high");
  a_branch_level: assert property ((ext_int_enable && $stable(pa_i[2]))[*4]
    |-> branch_if_int_high == pa_i[2] && branch_if_int_low == !pa_i[2])
    else $error("branch level wrong");
  a_dir_to_oe: assert property (wr && addr == `GPP_OFF_PB_DIR
    ##1 (!(wr && addr == `GPP_OFF_PB_DIR))[*2] |-> ##1 pb_oe_n == ~$past(wdata, 3))
    else $error("direction not applied");
  c_masked_read: cover property (rd && addr == `GPP_OFF_PA_DATA ##1 ext_int_enable);
  c_pull_write: cover property (wr && addr == `GPP_OFF_PB_PULLUP);
  c_branch_low: cover property (ext_int_enable && !branch_if_int_high);
endmodule
bind gpp_port gpp_port_props i_gpp_port_props (.clk, .rst_n, .addr, .wdata, .wr, .rd,
  .rdata, .pa_i, .pa_o, .pa_oe_n, .pa_pull_en, .pb_oe_n, .pb_pull_en, .ext_int_enable,
  .branch_if_int_high, .branch_if_int_low);

/* File: verification/test_gpp_port.sv */
`timescale 1ns/10ps
`include "gpp_defs.vh"
// Register-level bench for the two ports.
module test_gpp_port;
  reg        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0; // Bus strobes idle.
  reg  [3:0] addr = 4'h0;
  // Pins are held low from outside at first so the reset reads see no floating level.
  reg  [7:0] wdata = 8'h00, pb_ext_v = 8'h00, pb_ext_en = 8'hff; // Outside drives.
  reg  [5:0] pa_ext_v = 6'h00, pa_ext_en = 6'h3f;
  wire [7:0] rdata, pb_i, pb_o, pb_oe_n, pb_pull_en;
  wire [5:0] pa_i, pa_o, pa_oe_n, pa_pull_en, kb_in, kb_en;
  wire       ext_en, ext_lvl, br_hi, br_lo;
  integer    n_errors = 0, num_checks = 0, k;
  // Free-running 200 MHz clock.
  initial forever #2.5 clk = ~clk;
  gpp_port i_gpp_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pa_i(pa_i), .pa_o(pa_o), .pa_oe_n(pa_oe_n),
    .pa_pull_en(pa_pull_en), .pb_i(pb_i), .pb_o(pb_o), .pb_oe_n(pb_oe_n),
    .pb_pull_en(pb_pull_en), .keyboard_interrupt_in(kb_in), .keyboard_interrupt_en(kb_en),
    .ext_int_enable(ext_en), .ext_int_level(ext_lvl), .branch_if_int_high(br_hi),
    .branch_if_int_low(br_lo));
  gpp_pins #(.W(6)) i_pa_pins (.clk(clk), .o(pa_o), .oe_n(pa_oe_n), .pull_en(pa_pull_en),
    .ext_v(pa_ext_v), .ext_en(pa_ext_en), .pin(pa_i));
  gpp_pins #(.W(8)) i_pb_pins (.clk(clk), .o(pb_o), .oe_n(pb_oe_n), .pull_en(pb_pull_en),
    .ext_v(pb_ext_v), .ext_en(pb_ext_en), .pin(pb_i));
  // Compare and count; four-state equality so an unknown never matches.
  task check(input [7:0] seen, input [7:0] exp, input string what);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write.
  task wr_reg(input [3:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read; data stand only in the following cycle.
  task rd_chk(input [3:0] a, input [7:0] exp, input string what);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp, what);
  endtask
  // Outputs and synchronisers need a few edges to follow.
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Verdict and end of run.
  task close_out;
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run.
  initial begin
    repeat (2000) @(posedge clk);
    n_errors = n_errors + 1;
    close_out;
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 9; k = k + 1) rd_chk(k == 8 ? 4'hf : k[3:0], 8'h00, "reset");
    // Upper nibble inputs driven from outside, lower nibble outputs.
    pb_ext_v <= 8'ha0; pb_ext_en <= 8'hf0;
    wr_reg(`GPP_OFF_PB_PULLUP, 8'hff); wr_reg(`GPP_OFF_PB_DIR, 8'h0f);
    wr_reg(`GPP_OFF_PB_DATA, 8'h5c);
    settle;
    check(pb_pull_en, 8'hf0, "pb pull");
    check(pb_oe_n, 8'hf0, "pb oe");
    check(pb_o, 8'h5c, "pb latch");
    rd_chk(`GPP_OFF_PB_DATA, 8'hac, "pb mixed");
    rd_chk(`GPP_OFF_PB_PULLUP, 8'hff, "pb pull reg");
    wr_reg(`GPP_OFF_PB_DIR, 8'hff);
    settle;
    check(pb_pull_en, 8'h00, "pb pull out");
    rd_chk(`GPP_OFF_PB_DATA, 8'h5c, "pb latch read");
    pb_ext_en <= 8'h00;
    wr_reg(`GPP_OFF_PB_PULLUP, 8'h00); wr_reg(`GPP_OFF_PB_DIR, 8'h00);
    settle;
    check(pb_pull_en, 8'h00, "pb pull off");
    check(pb_oe_n, 8'hff, "pb hi z");
    // First port: shared pin stays an input whatever its direction bit says.
    pa_ext_en <= 6'h00;
    wr_reg(`GPP_OFF_PA_PULLUP, 8'h3f);
    settle;
    check({2'b00, pa_pull_en}, 8'h3f, "pa pull");
    wr_reg(`GPP_OFF_PA_DIR, 8'h3f); wr_reg(`GPP_OFF_PA_DATA, 8'h3f);
    settle;
    check({2'b00, pa_oe_n}, 8'h04, "pa oe");
    check({2'b00, pa_o}, 8'h3b, "pa drive");
    check({2'b00, pa_pull_en}, 8'h04, "pa pull out");
    rd_chk(`GPP_OFF_PA_DIR, 8'h3f, "pa dir");
    rd_chk(`GPP_OFF_PA_DATA, 8'h3f, "pa data");
    // Shared pin with the external interrupt off, then on.
    @(posedge clk) pa_ext_en <= 6'h04;
    settle;
    rd_chk(`GPP_OFF_PA_DATA, 8'h3b, "pa pin low");
    check({7'h00, br_hi}, 8'h01, "branch off");
    @(posedge clk) pa_ext_v <= 6'h04;
    settle;
    rd_chk(`GPP_OFF_PA_DATA, 8'h3f, "pa pin high");
    wr_reg(`GPP_OFF_CFG_TWO, 8'h01);
    settle;
    rd_chk(`GPP_OFF_PA_DATA, 8'h3b, "pa masked");
    check({7'h00, br_hi}, 8'h01, "branch high");
    @(posedge clk) pa_ext_v <= 6'h00;
    settle;
    check({6'h00, br_hi, br_lo}, 8'h01, "branch low");
    check({7'h00, ext_lvl}, 8'h00, "int level");
    check({7'h00, ext_en}, 8'h01, "int enable");
    wr_reg(`GPP_OFF_KB_ENABLE, 8'hff);
    settle;
    rd_chk(`GPP_OFF_KB_ENABLE, 8'h3f, "kb enable");
    check({2'b00, kb_en}, 8'h3f, "kb en view");
    check({2'b00, kb_in}, 8'h3b, "kb in view");
    close_out;
  end
endmodule
